// ===== hdl/wwdt_top.sv
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module wwdt_top
	import wwdt_pkg::*;
#(
	parameter int BASE_TICKS = PS_BASE
) (
	input  wire logic              CORE_CLK_I,
	input  wire logic              RESET_I,
	input  wire logic              OSC_128K_I,
	input  wire logic              ALWAYS_ON_FUSE_I,
	input  wire logic              CLK_MON_I,
	input  wire logic              KICK_I,
	input  wire logic              GIE_I,
	input  wire logic              IRQ_ACK_I,
	output logic                   IRQ_O,
	output logic                   WAKE_O,
	output logic                   WDT_RESET_O,
	input  wire logic              S_AXI_AWVALID_I,
	output logic                   S_AXI_AWREADY_O,
	input  wire logic [AXI_AW-1:0] S_AXI_AWADDR_I,
	input  wire logic              S_AXI_WVALID_I,
	output logic                   S_AXI_WREADY_O,
	input  wire logic [AXI_DW-1:0] S_AXI_WDATA_I,
	input  wire logic [3:0]        S_AXI_WSTRB_I,
	output logic                   S_AXI_BVALID_O,
	input  wire logic              S_AXI_BREADY_I,
	output logic [1:0]             S_AXI_BRESP_O,
	input  wire logic              S_AXI_ARVALID_I,
	output logic                   S_AXI_ARREADY_O,
	input  wire logic [AXI_AW-1:0] S_AXI_ARADDR_I,
	output logic                   S_AXI_RVALID_O,
	input  wire logic              S_AXI_RREADY_I,
	output logic [AXI_DW-1:0]      S_AXI_RDATA_O,
	output logic [1:0]             S_AXI_RRESP_O
);

	////////////////////////////////////////////////////////////////////////////
	// input synchronisers: oscillator, fuse, clock monitor

	logic [2:0]       sync1;
	logic [2:0]       sync2;
	logic             osc_d;
	wire  logic [2:0] raw_in = {CLK_MON_I, ALWAYS_ON_FUSE_I, OSC_128K_I};

	// each pin gets its own two-stage chain, first stage read only by second
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge CORE_CLK_I) begin
				if (RESET_I) begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
				end else begin
					sync1[gi] <= raw_in[gi];
					sync2[gi] <= sync1[gi];
				end
			end
		end
	endgenerate

	wire logic osc_s  = sync2[0];
	wire logic fuse_s = sync2[1];
	wire logic mon_s  = sync2[2];
	wire logic tick   = osc_s & ~osc_d;

	////////////////////////////////////////////////////////////////////////////
	// state

	logic             reset_enable_bit;
	logic             irq_enable_bit;
	logic             flag;
	logic             rcf;
	logic [3:0]       sel;
	logic [2:0]       ce_cnt;
	logic [CNT_W-1:0] cnt;

	////////////////////////////////////////////////////////////////////////////
	// bus write path: address and data held until the response is taken

	logic              aw_rdy;
	logic              w_rdy;
	logic [AXI_AW-1:0] waddr;
	logic [7:0]        wbyte;
	logic              wlane;

	wire logic       do_write = ~aw_rdy & ~w_rdy & ~S_AXI_BVALID_O;
	wire logic       ctrl_hit = (waddr == OFS_CTRL);
	wire logic       stat_hit = (waddr == OFS_STAT);
	wire logic       wr_ctrl  = do_write & ctrl_hit & wlane;
	wire logic       wr_stat  = do_write & stat_hit & wlane;
	wire wwdt_ctrl_t wr       = wwdt_ctrl_t'(wbyte);

	////////////////////////////////////////////////////////////////////////////
	// effective mode: fuse and clock monitor override the enable bits

	wire logic forced  = fuse_s | mon_s;
	wire logic eff_rst = forced | reset_enable_bit | rcf;
	wire logic eff_irq = ~forced & irq_enable_bit;
	wire logic running = eff_rst | eff_irq;

	// limit is base << code; reserved codes behave as the longest code
	wire logic [3:0]       sel_c   = (sel > PS_MAX_CODE) ? PS_MAX_CODE : sel;
	wire logic [CNT_W-1:0] lim     = CNT_W'((BASE_TICKS << sel_c) - 1);
	wire logic             expire  = running & tick & (cnt >= lim);
	wire logic             flag_set = expire & eff_irq;
	wire logic             rst_req  = expire & eff_rst & (~eff_irq | flag);

	// change window decode
	wire logic win = (ce_cnt != 3'h0);
	wire logic arm = wr_ctrl & wr.ce & wr.rst_en;
	wire logic chg = wr_ctrl & ~wr.ce & win;

	////////////////////////////////////////////////////////////////////////////
	// next values for the control state

	logic             next_wde;
	logic             next_irq_enable_bit;
	logic             next_flag;
	logic             next_rcf;
	logic [3:0]       next_sel;
	logic [2:0]       next_ce;
	logic [CNT_W-1:0] next_cnt;

	// setting reset enable is always allowed; clearing only in the window
	assign next_wde = (wr_ctrl & wr.rst_en) ? 1'b1 :
	                  (chg & ~rcf)          ? 1'b0 : reset_enable_bit;
	assign next_sel = chg ? {wr.ps3, wr.ps_lo} : sel;
	// vectoring in combined mode drops back to reset-only mode
	assign next_irq_enable_bit = (IRQ_ACK_I & eff_rst) ? 1'b0 :
	                   wr_ctrl               ? wr.irq_en : irq_enable_bit;
	// a new expiry outranks a clear arriving in the same cycle
	assign next_flag = flag_set ? 1'b1 :
	                   (IRQ_ACK_I | (wr_ctrl & wr.flag)) ? 1'b0 : flag;
	assign next_rcf  = rst_req ? 1'b1 :
	                   (wr_stat & ~wbyte[STAT_RCF_BIT]) ? 1'b0 : rcf;
	assign next_ce   = arm ? CE_WINDOW :
	                   win ? ce_cnt - 3'h1 : ce_cnt;
	// kick wins over counting; an idle timer sits at zero
	assign next_cnt  = (KICK_I | ~running) ? '0 :
	                   expire ? '0 :
	                   tick   ? cnt + CNT_W'(1) : cnt;

	// control registers
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			reset_enable_bit    <= WDE_RESET;
			irq_enable_bit   <= 1'b0;
			flag   <= 1'b0;
			rcf    <= 1'b0;
			sel    <= PS_RESET;
			ce_cnt <= 3'h0;
			cnt    <= '0;
			osc_d  <= 1'b0;
		end else begin
			reset_enable_bit    <= next_wde;
			irq_enable_bit   <= next_irq_enable_bit;
			flag   <= next_flag;
			rcf    <= next_rcf;
			sel    <= next_sel;
			ce_cnt <= next_ce;
			cnt    <= next_cnt;
			osc_d  <= osc_s;
		end
	end

	// outputs: interrupt gated by global enable, wake ignores it
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			IRQ_O       <= 1'b0;
			WAKE_O      <= 1'b0;
			WDT_RESET_O <= 1'b0;
		end else begin
			IRQ_O       <= flag & eff_irq & GIE_I;
			WAKE_O      <= flag & eff_irq;
			WDT_RESET_O <= rst_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read view of the registers

	wire logic [7:0] ctrl_rd = {flag, eff_irq & ~forced ? irq_enable_bit : 1'b0, sel[3], win,
	                            fuse_s | reset_enable_bit | rcf, sel[2:0]};
	wire logic [7:0] stat_rd = 8'(rcf) << STAT_RCF_BIT;
	wire logic       rd_hit  = (S_AXI_ARADDR_I == OFS_CTRL) | (S_AXI_ARADDR_I == OFS_STAT);
	wire logic [7:0] rd_byte = (S_AXI_ARADDR_I == OFS_CTRL) ? ctrl_rd :
	                           (S_AXI_ARADDR_I == OFS_STAT) ? stat_rd : 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channels: one write in flight, response one cycle later

	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			aw_rdy <= 1'b1;
			w_rdy  <= 1'b1;
			waddr  <= '0;
			wbyte  <= 8'h00;
			wlane  <= 1'b0;
		end else begin
			if (S_AXI_AWVALID_I & aw_rdy) begin
				aw_rdy <= 1'b0;
				waddr  <= S_AXI_AWADDR_I;
			end else if (S_AXI_BVALID_O & S_AXI_BREADY_I) begin
				aw_rdy <= 1'b1;
			end
			if (S_AXI_WVALID_I & w_rdy) begin
				w_rdy <= 1'b0;
				wbyte <= S_AXI_WDATA_I[7:0];
				wlane <= S_AXI_WSTRB_I[0];
			end else if (S_AXI_BVALID_O & S_AXI_BREADY_I) begin
				w_rdy <= 1'b1;
			end
		end
	end

	assign S_AXI_AWREADY_O = aw_rdy;
	assign S_AXI_WREADY_O  = w_rdy;

	// write response; unmapped addresses answer slave error
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O  <= RESP_OKAY;
		end else if (do_write) begin
			S_AXI_BVALID_O <= 1'b1;
			S_AXI_BRESP_O  <= (ctrl_hit | stat_hit) ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_BREADY_I) begin
			S_AXI_BVALID_O <= 1'b0;
		end
	end

	// read channel: data captured at the address handshake
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			S_AXI_ARREADY_O <= 1'b1;
			S_AXI_RVALID_O  <= 1'b0;
			S_AXI_RDATA_O   <= '0;
			S_AXI_RRESP_O   <= RESP_OKAY;
		end else if (S_AXI_ARVALID_I & S_AXI_ARREADY_O) begin
			S_AXI_ARREADY_O <= 1'b0;
			S_AXI_RVALID_O  <= 1'b1;
			S_AXI_RDATA_O   <= {24'h000000, rd_byte};
			S_AXI_RRESP_O   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RVALID_O & S_AXI_RREADY_I) begin
			S_AXI_ARREADY_O <= 1'b1;
			S_AXI_RVALID_O  <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RESET_I);

	property p_kick;
		KICK_I |=> (cnt == '0);
	endproperty
	a_kick: assert property (p_kick) else $error("kick did not restart counter");

	// reference limit built as a shifted count; a shortened period still expires at once
	property p_limit;
		(running && tick) |-> (expire == (cnt >= (CNT_W'(BASE_TICKS) << sel_c) - CNT_W'(1)));
	endproperty
	a_limit: assert property (p_limit) else $error("expiry at wrong count");

	property p_fuse;
		fuse_s |-> (ctrl_rd[3] && !eff_irq && eff_rst);
	endproperty
	a_fuse: assert property (p_fuse) else $error("fuse did not force reset mode");

	property p_mon;
		mon_s |-> (eff_rst && !eff_irq);
	endproperty
	a_mon: assert property (p_mon) else $error("clock monitor did not force reset mode");

	property p_ce_arm;
		arm |=> (ce_cnt == CE_WINDOW);
	endproperty
	a_ce_arm: assert property (p_ce_arm) else $error("window not opened");

	property p_ce_close;
		(ce_cnt == 3'h1 && !arm) |=> !win;
	endproperty
	a_ce_close: assert property (p_ce_close) else $error("window stayed open");

	property p_refuse;
		(do_write && !win) |=> (sel == $past(sel));
	endproperty
	a_refuse: assert property (p_refuse) else $error("prescale changed outside window");

	property p_irq;
		IRQ_O |-> $past(flag && eff_irq && GIE_I);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt without its enables");

	property p_pulse;
		WDT_RESET_O |-> rcf ##1 !WDT_RESET_O;
	endproperty
	a_pulse: assert property (p_pulse) else $error("reset pulse wrong");

	property p_rcf_wde;
		rcf |-> (ctrl_rd[3] && eff_rst);
	endproperty
	a_rcf_wde: assert property (p_rcf_wde) else $error("reset enable fell under cause flag");

	property p_ack;
		(IRQ_ACK_I && !flag_set) |=> !flag;
	endproperty
	a_ack: assert property (p_ack) else $error("vector did not clear flag");

	c_irq:  cover property (flag_set ##1 flag);
	c_rst:  cover property (rst_req ##1 WDT_RESET_O);
	c_chg:  cover property (arm ##[1:4] chg);
	c_kick: cover property (running && KICK_I);

endmodule

// ===== hdl/wwdt_pkg.sv
package wwdt_pkg;
	// bus geometry
	localparam int          AXI_AW       = 8;
	localparam int          AXI_DW       = 32;
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_STAT     = 8'h04;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	// timing: oscillator and system clock rates, change window length
	localparam int          OSC_HZ       = 128000;
	localparam int          CORE_HZ      = 20000000;
	localparam logic [2:0]  CE_WINDOW    = 3'h4;
	// time-out base in oscillator cycles, doubled per select step
	localparam int          PS_BASE      = 2048;
	localparam logic [3:0]  PS_MAX_CODE  = 4'h9;
	localparam int          CNT_W        = 20;
	// field positions and reset values
	localparam int          STAT_RCF_BIT = 3;
	localparam logic [3:0]  PS_RESET     = 4'h0;
	localparam logic        WDE_RESET    = 1'b0;

	// control byte layout
	typedef struct packed {
		logic       flag;
		logic       irq_en;
		logic       ps3;
		logic       ce;
		logic       rst_en;
		logic [2:0] ps_lo;
	} wwdt_ctrl_t;
endpackage

// ===== testbench/windowless_watchdog_timer_bench.sv
`timescale 1ns/1ps
module windowless_watchdog_timer_bench;
	import wwdt_pkg::*;
	localparam int BT = 4;
	logic        clk = 0, rst = 1, osc = 0, fuse = 0, mon = 0, kick = 0, gie = 0, ack = 0;
	logic        irq, wake, wrst, awrdy, wrdy, bv, arrdy, rv;
	logic        awv = 0, wv = 0, arv = 0;
	logic [7:0]  awa = 0, ara = 0;
	logic [31:0] wd = 0, rd_d, seed = 32'h00002C6B;
	logic [1:0]  bresp, rresp, rsp, osc_div = 0;
	int          n_fail = 0, samples_checked = 0, n_rst = 0, t, n, n0;

	always #25 clk = ~clk;
	// oscillator stand-in, one tick per four clocks so the shortened counts stay quick
	always @(posedge clk) begin
		osc_div <= osc_div + 2'h1;
		osc <= osc_div[1];
		if (wrst === 1'b1)
			n_rst <= n_rst + 1;
	end

	// ready lines held high: the bench always accepts answers at once
	wwdt_top #(.BASE_TICKS(BT)) i_dut (
		.CORE_CLK_I(clk), .RESET_I(rst), .OSC_128K_I(osc), .ALWAYS_ON_FUSE_I(fuse),
		.CLK_MON_I(mon), .KICK_I(kick), .GIE_I(gie), .IRQ_ACK_I(ack),
		.IRQ_O(irq), .WAKE_O(wake), .WDT_RESET_O(wrst),
		.S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy), .S_AXI_AWADDR_I(awa),
		.S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF),
		.S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(1'b1), .S_AXI_BRESP_O(bresp),
		.S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arrdy), .S_AXI_ARADDR_I(ara),
		.S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(1'b1), .S_AXI_RDATA_O(rd_d), .S_AXI_RRESP_O(rresp)
	);

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// expiry window in clocks: ticks times oscillator divide, plus sync slack
	function automatic logic in_win(input int k, input int c);
		return c >= (k - 1) * 4 - 16 && c <= k * 4 + 8;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic tmo(input int k);
		if (k > 10000) begin
			chk(0, 1);
			final_report();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= d;
		for (int k = 0; k <= 10001; k++) begin
			@(posedge clk);
			tmo(k);
			if (awrdy)
				awv <= 1'b0;
			if (wrdy)
				wv <= 1'b0;
			if (bv) begin
				rsp = bresp;
				break;
			end
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		arv <= 1'b1;
		ara <= a;
		for (int k = 0; k <= 10001; k++) begin
			@(posedge clk);
			tmo(k);
			if (arrdy)
				arv <= 1'b0;
			if (rv) begin
				chk(rd_d, e);
				chk(rresp, er);
				break;
			end
		end
	endtask
	// one-cycle pulse on the kick or the vector acknowledge
	task automatic pls(input logic k);
		if (k)
			kick <= 1'b1;
		else
			ack <= 1'b1;
		@(posedge clk);
		kick <= 1'b0;
		ack <= 1'b0;
	endtask
	task automatic setc(input logic [7:0] v);
		wr(OFS_CTRL, {24'h0, v | 8'h18});
		wr(OFS_CTRL, {24'h0, v & 8'hEF});
	endtask
	// sel 0 reset request, 1 wake, 2 interrupt; sampled at clock edges
	task automatic wt(input int sel);
		t = 0;
		do begin
			@(posedge clk);
			t++;
			tmo(t);
		end while (!((sel == 0) ? wrst === 1'b1 : (sel == 1) ? wake === 1'b1 : irq === 1'b1));
	endtask
	task automatic rst_dut();
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_dut();
		rc(OFS_CTRL, 32'h0, RESP_OKAY);
		rc(OFS_STAT, 32'h0, RESP_OKAY);
		rc(8'h08, 32'h0, RESP_SLVERR);
		wr(8'h0C, 32'h0);
		chk(rsp, RESP_SLVERR);
		wr(OFS_CTRL, 32'h27);
		rc(OFS_CTRL, 32'h00, RESP_OKAY);
		// late change write after the unlock must be ignored
		wr(OFS_CTRL, 32'h18);
		repeat (5) @(posedge clk);
		wr(OFS_CTRL, 32'h03);
		rc(OFS_CTRL, 32'h08, RESP_OKAY);
		// every prescale code 0 to 9 in reset mode, reserved code 10 last
		for (int c = 0; c <= 10; c++) begin
			n = BT << ((c > 9) ? 9 : c);
			rst_dut();
			pls(1);
			setc({2'b00, c[3], 2'b01, c[2:0]});
			pls(1);
			n0 = n_rst;
			repeat (2 + rnd() % 3) begin
				// at least one edge between kicks so the strobe is never driven twice at once
				repeat (1 + rnd() % (2 * n - 1)) @(posedge clk);
				pls(1);
			end
			wt(0);
			chk(in_win(n, t), 1'b1);
			@(posedge clk);
			chk(wrst, 1'b0);
			chk(n_rst - n0, 1);
			rc(OFS_STAT, 32'h08, RESP_OKAY);
			rc(OFS_CTRL, {26'h0, c[3], 2'b01, c[2:0]}, RESP_OKAY);
			if (c == 0) begin
				setc(8'h00);
				rc(OFS_CTRL, 32'h08, RESP_OKAY);
				pls(1);
				wr(OFS_STAT, 32'h0);
				rc(OFS_STAT, 32'h0, RESP_OKAY);
				pls(1);
				setc(8'h00);
				rc(OFS_CTRL, 32'h00, RESP_OKAY);
				n0 = n_rst;
				repeat (200) @(posedge clk);
				chk(n_rst - n0, 0);
				chk(wake, 1'b0);
			end
		end
		// interrupt mode, code 3
		rst_dut();
		gie <= 1'b1;
		pls(1);
		setc(8'h43);
		n0 = n_rst;
		wt(1);
		chk(in_win(32, t), 1'b1);
		@(posedge clk);
		chk(irq, 1'b1);
		gie <= 1'b0;
		repeat (2) @(posedge clk);
		chk({irq, wake}, 2'b01);
		rc(OFS_CTRL, 32'hC3, RESP_OKAY);
		wr(OFS_CTRL, 32'hC3);
		rc(OFS_CTRL, 32'h43, RESP_OKAY);
		chk(n_rst - n0, 0);
		// combined mode: interrupt first, vector drops to reset only
		rst_dut();
		gie <= 1'b1;
		pls(1);
		setc(8'h4B);
		n0 = n_rst;
		wt(2);
		chk(n_rst - n0, 0);
		pls(0);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		rc(OFS_CTRL, 32'h0B, RESP_OKAY);
		wt(0);
		chk(in_win(32, t), 1'b1);
		// software re-arms the interrupt enable after the handler, back to combined mode
		wr(OFS_CTRL, 32'h4B);
		rc(OFS_CTRL, 32'h4B, RESP_OKAY);
		wt(2);
		chk(in_win(32, t), 1'b1);
		chk(n_rst - n0, 1);
		gie <= 1'b0;
		// fuse, then clock monitor, each forces reset only
		for (int i = 0; i < 2; i++) begin
			rst_dut();
			fuse <= (i == 0);
			mon <= (i == 1);
			repeat (3) @(posedge clk);
			wr(OFS_CTRL, 32'h40);
			rc(OFS_CTRL, (i == 0) ? 32'h08 : 32'h00, RESP_OKAY);
			wt(0);
			chk(t <= 24, 1'b1);
			chk(wake, 1'b0);
		end
		fuse <= 1'b0;
		mon <= 1'b0;
		final_report();
	end
endmodule
